/* verilog/idt_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module idt_decoder (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [23:0] i_fetch_word,
    input wire logic i_fetch_valid,
    output logic o_fetch_ready,
    input wire logic i_cond_true,
    input wire idt_pkg::idt_flag_upd_t i_flag_upd,
    input wire logic i_zero_sticky,
    output var idt_pkg::idt_dec_t o_dec,
    output logic o_dec_valid,
    output logic o_nop_cycle,
    output var idt_pkg::idt_flags_t o_flags,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);

idt_pkg::idt_state_t st_r;
idt_pkg::idt_state_t st_nxt;

// ==========================================================
// field decode of one program word
function automatic idt_pkg::idt_dec_t decode(input logic [23:0] w, input logic cond);
    idt_pkg::idt_dec_t d;
    logic [7:0] op;
    logic [3:0] sel;
    d = '0;
    op = w[23:16];
    sel = w[15:12];
    d.opcode = op;
    d.cycles = idt_pkg::CYC_ONE;
    d.size = idt_pkg::SZ_WORD;
    case (op)
        idt_pkg::OP_NOP: begin
            d.illegal = 1'b0;
        end
        idt_pkg::OP_CALL2, idt_pkg::OP_GOTO2, idt_pkg::OP_LOOP2: begin
            d.dbl = 1'b1;
            d.cycles = idt_pkg::CYC_TWO;
            d.program_address_literal[15:0] = w[15:0];
            d.illegal = w[0];
        end
        idt_pkg::OP_JIND: begin
            d.second_source_register = w[3:0];
            d.cycles = idt_pkg::CYC_TWO;
        end
        idt_pkg::OP_RET, idt_pkg::OP_RETI: begin
            d.cycles = idt_pkg::CYC_RETURN;
        end
        idt_pkg::OP_JUMP: begin
            d.literal = w[15:0];
            d.cycles = idt_pkg::CYC_TWO;
        end
        idt_pkg::OP_BRCC: begin
            d.literal = w[15:0];
            d.cycles = cond ? idt_pkg::CYC_TWO : idt_pkg::CYC_ONE;
        end
        idt_pkg::OP_REG, idt_pkg::OP_REG_B: begin
            d.size = op[0] ? idt_pkg::SZ_BYTE : idt_pkg::SZ_WORD;
            d.base_source_register = w[15:12];
            d.dst_mode = w[11:10];
            d.result_register = w[9:6];
            d.src_mode = w[5:4];
            d.second_source_register = w[3:0];
        end
        idt_pkg::OP_FILE, idt_pkg::OP_FILE_B: begin
            d.size = op[0] ? idt_pkg::SZ_BYTE : idt_pkg::SZ_WORD;
            d.to_file = w[15];
            d.file_addr = w[12:0];
            d.result_register = idt_pkg::REG_DEFAULT;
            d.illegal = (w[14:13] != 2'h0);
        end
        idt_pkg::OP_LITR, idt_pkg::OP_LITR_B: begin
            d.size = op[0] ? idt_pkg::SZ_BYTE : idt_pkg::SZ_WORD;
            d.base_source_register = w[15:12];
            d.dest_separate = (w[11:8] != w[15:12]);
            d.result_register = w[11:8];
            d.dst_mode = d.dest_separate ? w[7:6] : 2'h0;
            d.literal = {11'h000, w[4:0]};
        end
        idt_pkg::OP_ULIT, idt_pkg::OP_ULIT_B: begin
            d.size = op[0] ? idt_pkg::SZ_BYTE : idt_pkg::SZ_WORD;
            d.literal = {6'h00, w[13:4]};
            d.result_register = w[3:0];
            d.base_source_register = w[3:0];
            d.illegal = op[0] & (w[13:12] != 2'h0);
        end
        idt_pkg::OP_SIGNED_S: begin
            d.literal = {{6{w[13]}}, w[13:4]};
            d.result_register = w[3:0];
        end
        idt_pkg::OP_SIGNED_L: begin
            d.literal = w[15:0];
            d.result_register = idt_pkg::REG_DEFAULT;
        end
        idt_pkg::OP_SKIP: begin
            d.skip = 1'b1;
            d.bit_index_field = w[7:4];
            d.second_source_register = w[3:0];
        end
        idt_pkg::OP_BITOP: begin
            d.bit_from_reg = w[15];
            d.base_source_register = w[14:11];
            d.src_mode = w[9:8];
            d.bit_index_field = w[7:4];
            d.second_source_register = w[3:0];
        end
        idt_pkg::OP_TBLRD, idt_pkg::OP_TBLWT: begin
            d.result_register = w[11:8];
            d.second_source_register = w[3:0];
            d.cycles = idt_pkg::CYC_TABLE;
        end
        idt_pkg::OP_MOVD: begin
            d.size = idt_pkg::SZ_DWORD;
            d.result_register = w[11:8];
            d.second_source_register = w[3:0];
            d.cycles = idt_pkg::CYC_TWO;
        end
        idt_pkg::OP_PUSHS: begin
            d.shadow = 1'b1;
        end
        idt_pkg::OP_MAC_A, idt_pkg::OP_MAC_B: begin
            d.acc_b = op[0];
            if (sel < idt_pkg::MUL_PAIRS) begin
                {d.mul_x, d.mul_y} = idt_pkg::MUL_PAIR_TAB[{sel[2:0], 3'h0} +: 8];
            end else if (sel[3:2] == idt_pkg::MUL_SQUARE) begin
                d.mul_x = idt_pkg::MUL_LO | {2'h0, sel[1:0]};
                d.mul_y = idt_pkg::MUL_LO | {2'h0, sel[1:0]};
            end else begin
                d.illegal = 1'b1;
            end
            d.x_prefetch = w[11:9];
            d.x_dest = w[8:7];
            d.y_prefetch = w[6:4];
            d.y_dest = w[3:2];
            d.accum_result_store_target = w[1:0];
            if (w[1:0] != idt_pkg::STORE_NONE) begin
                d.result_register = idt_pkg::STORE_REG;
            end
            if (w[1:0] > idt_pkg::STORE_POSTINC) begin
                d.illegal = 1'b1;
            end
        end
        idt_pkg::OP_DSP_A, idt_pkg::OP_DSP_B: begin
            d.acc_b = op[0];
            d.shift_by_reg = w[15];
            d.second_source_register = w[14:11];
            d.src_mode = w[10:9];
            if (w[15]) begin
                d.base_source_register = w[3:0];
            end else begin
                d.shift_amount = w[5:0];
            end
        end
        default: begin
            d.illegal = 1'b1;
        end
    endcase
    return d;
endfunction : decode

// ==========================================================
// next state
always_comb begin
    idt_pkg::idt_dec_t d;
    logic take;
    logic [31:0] m;
    logic [31:0] wv;
    logic ar_take;
    d = decode(i_fetch_word, i_cond_true);
    take = i_fetch_valid & st_r.fetch_ready;
    m = {{8{st_r.wstrb[3]}}, {8{st_r.wstrb[2]}}, {8{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    wv = st_r.wdata & m;
    ar_take = i_s_axi_arvalid & st_r.arready;
    st_nxt = st_r;
    st_nxt.dec_valid = 1'b0;
    st_nxt.nop_cycle = 1'b0;

    case (st_r.seq)
        idt_pkg::SEQ_RUN: begin
            if (take) begin
                st_nxt.dec = d;
                if (d.dbl) begin
                    st_nxt.seq = idt_pkg::SEQ_WAIT2;
                end else begin
                    st_nxt.dec_valid = 1'b1;
                    if (d.skip & i_cond_true) begin
                        st_nxt.seq = idt_pkg::SEQ_SKIP;
                    end else if (d.cycles > idt_pkg::CYC_ONE) begin
                        st_nxt.seq = idt_pkg::SEQ_STALL;
                        st_nxt.stall = d.cycles - idt_pkg::CYC_ONE;
                    end
                end
            end
        end
        idt_pkg::SEQ_WAIT2: begin
            if (take) begin
                st_nxt.dec.program_address_literal[22:16] = i_fetch_word[6:0];
                st_nxt.dec.illegal = st_r.dec.illegal | (i_fetch_word[23:16] != idt_pkg::OP_NOP);
                st_nxt.dec_valid = 1'b1;
                st_nxt.seq = idt_pkg::SEQ_RUN;
            end
        end
        idt_pkg::SEQ_STALL: begin
            st_nxt.nop_cycle = 1'b1;
            st_nxt.stall = st_r.stall - idt_pkg::CYC_ONE;
            if (st_r.stall == idt_pkg::CYC_ONE) begin
                st_nxt.seq = idt_pkg::SEQ_RUN;
            end
        end
        idt_pkg::SEQ_SKIP: begin
            if (take) begin
                st_nxt.nop_cycle = 1'b1;
                st_nxt.seq = d.dbl ? idt_pkg::SEQ_SKIP2 : idt_pkg::SEQ_RUN;
            end
        end
        idt_pkg::SEQ_SKIP2: begin
            if (take) begin
                st_nxt.nop_cycle = 1'b1;
                st_nxt.seq = idt_pkg::SEQ_RUN;
            end
        end
        default: begin
            st_nxt.seq = idt_pkg::SEQ_RUN;
        end
    endcase

    if (take | (st_r.seq == idt_pkg::SEQ_STALL)) begin
        st_nxt.cyc_count = st_r.cyc_count + 32'h1;
    end

    // write channel: address and data in either order
    if (i_s_axi_awvalid & st_r.awready) begin
        st_nxt.aw_got = 1'b1;
        st_nxt.aw_addr = {i_s_axi_awaddr[7:2], 2'h0};
    end
    if (i_s_axi_wvalid & st_r.wready) begin
        st_nxt.w_got = 1'b1;
        st_nxt.wdata = i_s_axi_wdata;
        st_nxt.wstrb = i_s_axi_wstrb;
    end
    if (st_r.bvalid & i_s_axi_bready) begin
        st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_got & st_r.w_got & ~st_r.bvalid) begin
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got = 1'b0;
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp = idt_pkg::RESP_OKAY;
        case (st_r.aw_addr)
            idt_pkg::REG_CTRL: begin
                if (st_r.wstrb[0]) begin
                    st_nxt.ctrl_hold = wv[idt_pkg::CTRL_HOLD_BIT];
                end
            end
            idt_pkg::REG_STATUS: begin
                st_nxt.flags = idt_pkg::idt_flags_t'((st_r.flags & ~m[8:0]) | wv[8:0]);
                if (wv[idt_pkg::STAT_ILLEGAL_BIT]) begin
                    st_nxt.illegal_seen = 1'b0;
                end
            end
            idt_pkg::REG_LAST, idt_pkg::REG_COUNT: begin
                st_nxt.bresp = idt_pkg::RESP_OKAY;
            end
            default: begin
                st_nxt.bresp = idt_pkg::RESP_SLVERR;
            end
        endcase
    end

    // datapath flag updates win over a software write
    st_nxt.flags = idt_pkg::idt_flags_t'((st_nxt.flags & ~i_flag_upd.mask)
        | (i_flag_upd.value & i_flag_upd.mask));
    if (i_zero_sticky & i_flag_upd.mask.zero_sticky) begin
        st_nxt.flags.zero_sticky = st_r.flags.zero_sticky & i_flag_upd.value.zero_sticky;
    end

    // illegal event sets after any clear
    if (st_nxt.dec_valid & st_nxt.dec.illegal) begin
        st_nxt.illegal_seen = 1'b1;
    end

    // read channel
    if (st_r.rvalid & i_s_axi_rready) begin
        st_nxt.rvalid = 1'b0;
    end
    if (ar_take) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rresp = idt_pkg::RESP_OKAY;
        st_nxt.rdata = 32'h0;
        case ({i_s_axi_araddr[7:2], 2'h0})
            idt_pkg::REG_CTRL: begin
                st_nxt.rdata[idt_pkg::CTRL_HOLD_BIT] = st_r.ctrl_hold;
            end
            idt_pkg::REG_STATUS: begin
                st_nxt.rdata[8:0] = st_r.flags;
                st_nxt.rdata[idt_pkg::STAT_ILLEGAL_BIT] = st_r.illegal_seen;
            end
            idt_pkg::REG_LAST: begin
                st_nxt.rdata[7:0] = st_r.dec.opcode;
                st_nxt.rdata[10:8] = st_r.dec.cycles;
            end
            idt_pkg::REG_COUNT: begin
                st_nxt.rdata = st_r.cyc_count;
            end
            default: begin
                st_nxt.rresp = idt_pkg::RESP_SLVERR;
            end
        endcase
    end

    st_nxt.awready = ~st_nxt.aw_got;
    st_nxt.wready = ~st_nxt.w_got;
    st_nxt.arready = ~st_nxt.rvalid;
    st_nxt.fetch_ready = ~st_nxt.ctrl_hold & (st_nxt.seq != idt_pkg::SEQ_STALL);
end

// ==========================================================
// state register
always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
        st_r <= '0;
    end else begin
        st_r <= st_nxt;
    end
end

// ==========================================================
// outputs
assign o_fetch_ready = st_r.fetch_ready;
assign o_dec = st_r.dec;
assign o_dec_valid = st_r.dec_valid;
assign o_nop_cycle = st_r.nop_cycle;
assign o_flags = st_r.flags;
assign o_s_axi_awready = st_r.awready;
assign o_s_axi_wready = st_r.wready;
assign o_s_axi_bresp = st_r.bresp;
assign o_s_axi_bvalid = st_r.bvalid;
assign o_s_axi_arready = st_r.arready;
assign o_s_axi_rdata = st_r.rdata;
assign o_s_axi_rresp = st_r.rresp;
assign o_s_axi_rvalid = st_r.rvalid;

endmodule : idt_decoder
`default_nettype wire

/* verilog/idt_pkg.sv */
// Operation
// - a program word is 24 bits and most instructions take one word
// - exactly three opcodes span two words, all others one
// - the top 8 bits select the instruction, the low 16 hold operands
// - a second word has a zero top byte and alone acts as nop
// - one cycle, two when a condition is true or the flow changes
// - branch, indirect jump, table access and returns take two or three cycles
// - a taken skip costs two cycles, three if the skipped op is two words
// - double-word moves and all two-word instructions take two cycles
// - register form decodes base, second source with mode, and result
// - direct memory form writes back to memory or to working register zero
// - the direct memory address reaches 0x1fff
// - a bit op takes its bit from a 4-bit index or from the base register
// - literal arithmetic keeps a separate result only if it differs from base
// - ten-bit unsigned literal is limited to 255 in byte mode
// - a program address literal is valid only with its low bit zero
// - signed literals of 10 and 16 bits are two's complement
// - accumulator A or B; result store to register 13 or its post-incremented target
// - multiply class decodes accumulator, factors, prefetches and store target
// - other dsp ops decode accumulator, operand with mode and shift amount
// - five integer flags are kept and updated by instructions
// - four accumulator overflow and saturation flags are kept
// - word size by default, byte, double word and shadow by suffix
// - working register fields select one of sixteen registers
// - multiply factors come from registers 4 to 7, squares use one of them
package idt_pkg;

// ==========================================================
// register map
localparam logic [7:0] REG_CTRL = 8'h00;
localparam logic [7:0] REG_STATUS = 8'h04;
localparam logic [7:0] REG_LAST = 8'h08;
localparam logic [7:0] REG_COUNT = 8'h0c;
localparam int CTRL_HOLD_BIT = 0;
localparam int STAT_ILLEGAL_BIT = 16;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

// ==========================================================
// opcodes
localparam logic [7:0] OP_NOP = 8'h00;
localparam logic [7:0] OP_JIND = 8'h01;
localparam logic [7:0] OP_CALL2 = 8'h02;
localparam logic [7:0] OP_GOTO2 = 8'h04;
localparam logic [7:0] OP_RET = 8'h06;
localparam logic [7:0] OP_RETI = 8'h07;
localparam logic [7:0] OP_LOOP2 = 8'h08;
localparam logic [7:0] OP_BRCC = 8'h30;
localparam logic [7:0] OP_JUMP = 8'h37;
localparam logic [7:0] OP_REG = 8'h40;
localparam logic [7:0] OP_REG_B = 8'h41;
localparam logic [7:0] OP_FILE = 8'h50;
localparam logic [7:0] OP_FILE_B = 8'h51;
localparam logic [7:0] OP_LITR = 8'h60;
localparam logic [7:0] OP_LITR_B = 8'h61;
localparam logic [7:0] OP_ULIT = 8'h68;
localparam logic [7:0] OP_ULIT_B = 8'h69;
localparam logic [7:0] OP_SIGNED_S = 8'h70;
localparam logic [7:0] OP_SIGNED_L = 8'h78;
localparam logic [7:0] OP_SKIP = 8'ha0;
localparam logic [7:0] OP_BITOP = 8'ha8;
localparam logic [7:0] OP_TBLRD = 8'hba;
localparam logic [7:0] OP_TBLWT = 8'hbb;
localparam logic [7:0] OP_MOVD = 8'hbe;
localparam logic [7:0] OP_MAC_A = 8'hc0;
localparam logic [7:0] OP_MAC_B = 8'hc1;
localparam logic [7:0] OP_DSP_A = 8'hc8;
localparam logic [7:0] OP_DSP_B = 8'hc9;
localparam logic [7:0] OP_PUSHS = 8'hfe;

// ==========================================================
// cycle counts and field limits
localparam logic [2:0] CYC_ONE = 3'h1;
localparam logic [2:0] CYC_TWO = 3'h2;
localparam logic [2:0] CYC_TABLE = 3'h2;
localparam logic [2:0] CYC_RETURN = 3'h3;
localparam logic [3:0] REG_DEFAULT = 4'h0;
localparam logic [3:0] STORE_REG = 4'hd;
localparam logic [1:0] STORE_NONE = 2'h0;
localparam logic [1:0] STORE_DIRECT = 2'h1;
localparam logic [1:0] STORE_POSTINC = 2'h2;
localparam logic [3:0] MUL_LO = 4'h4;
localparam logic [3:0] MUL_PAIRS = 4'h6;
localparam logic [1:0] MUL_SQUARE = 2'h2;
localparam logic [47:0] MUL_PAIR_TAB = 48'h675756474645;

// ==========================================================
// types
typedef enum logic [1:0] {SZ_WORD, SZ_BYTE, SZ_DWORD} idt_size_t;
typedef enum logic [2:0] {SEQ_RUN, SEQ_WAIT2, SEQ_STALL, SEQ_SKIP, SEQ_SKIP2} idt_seq_t;

typedef struct packed {
    logic accum_b_clamped_flag;
    logic accum_a_clamped_flag;
    logic accum_b_overflow_flag;
    logic accum_a_overflow_flag;
    logic zero_sticky;
    logic signed_range_exceeded_flag;
    logic negative;
    logic half_carry_flag;
    logic carry;
} idt_flags_t;

typedef struct packed {
    idt_flags_t mask;
    idt_flags_t value;
} idt_flag_upd_t;

typedef struct packed {
    logic [7:0] opcode;
    logic dbl;
    logic skip;
    logic [2:0] cycles;
    idt_size_t size;
    logic shadow;
    logic [3:0] base_source_register;
    logic [3:0] second_source_register;
    logic [1:0] src_mode;
    logic [3:0] result_register;
    logic [1:0] dst_mode;
    logic dest_separate;
    logic [12:0] file_addr;
    logic to_file;
    logic [3:0] bit_index_field;
    logic bit_from_reg;
    logic [15:0] literal;
    logic [22:0] program_address_literal;
    logic acc_b;
    logic [3:0] mul_x;
    logic [3:0] mul_y;
    logic [2:0] x_prefetch;
    logic [1:0] x_dest;
    logic [2:0] y_prefetch;
    logic [1:0] y_dest;
    logic [1:0] accum_result_store_target;
    logic shift_by_reg;
    logic [5:0] shift_amount;
    logic illegal;
} idt_dec_t;

typedef struct packed {
    idt_seq_t seq;
    logic [2:0] stall;
    logic fetch_ready;
    idt_dec_t dec;
    logic dec_valid;
    logic nop_cycle;
    idt_flags_t flags;
    logic illegal_seen;
    logic ctrl_hold;
    logic [31:0] cyc_count;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
} idt_state_t;

endpackage : idt_pkg

/* testbench/idt_decoder_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module idt_decoder_monitor (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire idt_pkg::idt_flag_upd_t i_flag_upd,
    input wire logic i_zero_sticky,
    input wire idt_pkg::idt_dec_t o_dec,
    input wire logic o_dec_valid,
    input wire logic o_nop_cycle,
    input wire idt_pkg::idt_flags_t o_flags,
    input wire logic o_fetch_ready
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [7:0] op;
    assign op = o_dec.opcode;
    // ========================================
    // decode and timing
    a_jump_stall: assert property (
        o_dec_valid && op == idt_pkg::OP_JUMP |->
        (o_dec.cycles == idt_pkg::CYC_TWO && !o_fetch_ready) ##1 o_nop_cycle)
        else $error("branch did not stall one nop cycle");
    a_ret_nops: assert property (
        o_dec_valid && (op == idt_pkg::OP_RET || op == idt_pkg::OP_RETI) |->
        (o_dec.cycles == idt_pkg::CYC_RETURN) ##1 o_nop_cycle [*2])
        else $error("return did not take two nop cycles");
    a_dbl_set: assert property (
        o_dec_valid |-> o_dec.dbl == (op == idt_pkg::OP_CALL2 || op == idt_pkg::OP_GOTO2
        || op == idt_pkg::OP_LOOP2)) else $error("two-word marking wrong");
    a_two_cycle: assert property (
        o_dec_valid && (o_dec.dbl || op == idt_pkg::OP_MOVD) |-> o_dec.cycles == 3'h2)
        else $error("double-word op not two cycles");
    a_odd_target: assert property (
        o_dec_valid && o_dec.dbl && o_dec.program_address_literal[0] |-> o_dec.illegal)
        else $error("odd program address accepted");
    a_lit_dest: assert property (
        o_dec_valid && op == idt_pkg::OP_LITR |-> o_dec.dest_separate ==
        (o_dec.result_register != o_dec.base_source_register))
        else $error("literal destination selection wrong");
    a_mul_pair: assert property (
        o_dec_valid && (op == idt_pkg::OP_MAC_A || op == idt_pkg::OP_MAC_B) && !o_dec.illegal
        |-> o_dec.mul_x[3:2] == 2'h1 && o_dec.mul_y[3:2] == 2'h1 && o_dec.acc_b == op[0])
        else $error("multiply operands outside 4 to 7");
    // ========================================
    // flags
    a_flag_load: assert property (
        (|i_flag_upd.mask) |=> ((o_flags ^ $past(i_flag_upd.value)) & $past(i_flag_upd.mask)
        & 9'h1ef) == 9'h0) else $error("flag update not loaded");
    a_zero_sticky: assert property (
        i_flag_upd.mask.zero_sticky && i_zero_sticky |=> o_flags.zero_sticky ==
        ($past(o_flags.zero_sticky) & $past(i_flag_upd.value.zero_sticky)))
        else $error("sticky zero not kept");
    c_nop: cover property (o_nop_cycle);
    c_dbl: cover property (o_dec_valid && o_dec.dbl);
    c_bad: cover property (o_dec_valid && o_dec.illegal);
endmodule : idt_decoder_monitor
bind idt_decoder idt_decoder_monitor u_idt_decoder_monitor (.i_sys_clk, .i_rst, .i_flag_upd,
    .i_zero_sticky, .o_dec, .o_dec_valid, .o_nop_cycle, .o_flags, .o_fetch_ready);
`default_nettype wire

/* testbench/idt_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module idt_prog_mem (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic i_ready,
    output logic o_valid,
    output logic [23:0] o_word,
    output logic o_cond
);
    logic [24:0] mem [0:63];
    logic [6:0] pc;
    logic [5:0] nx;
    assign nx = pc[5:0] + 6'h01;
    // ========================================
    // words after an index with bit 2 set leave an idle gap with inverted lines
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_word <= 24'h0;
            o_cond <= 1'b0;
            pc <= 7'h00;
        end else if (o_valid && i_ready) begin
            pc <= pc + 7'h01;
            o_valid <= !pc[2] && pc != 7'h3f;
            o_word <= pc[2] ? ~o_word : mem[nx][23:0];
            o_cond <= pc[2] ? ~o_cond : mem[nx][24];
        end else if (!o_valid && i_run && !pc[6]) begin
            o_valid <= 1'b1;
            o_word <= mem[pc[5:0]][23:0];
            o_cond <= mem[pc[5:0]][24];
        end
    end
endmodule : idt_prog_mem
`default_nettype wire

/* testbench/idt_decoder_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module idt_decoder_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic zs = 1'b0;
    idt_pkg::idt_flag_upd_t fu = '0;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic bry = 1'b0;
    logic arv = 1'b0;
    logic rry = 1'b0;
    logic fv, frdy, cond, dv, nop, awr, wr, bv, arr, rv;
    logic [23:0] fw;
    logic [1:0] br, rr;
    logic [31:0] rd, v;
    idt_pkg::idt_dec_t dec;
    idt_pkg::idt_flags_t fl;
    idt_pkg::idt_dec_t rec [0:31];
    int nd = 0;
    int nn = 0;
    int error_cnt = 0;
    int n_compared = 0;
    logic [31:0] prog [0:24] = '{32'h370000, 32'h060000, 32'h021234, 32'h000005, 32'h040001,
        32'h0, 32'h080000, 32'h010000, 32'h0, 32'h1a00000, 32'h020000, 32'h0, 32'h1a00000,
        32'h400000, 32'ha00000, 32'h400000, 32'hff0000, 32'hbe0000, 32'h1300000, 32'h300000,
        32'hc08002, 32'hc10001, 32'h601234, 32'hba0000, 32'h070000};
    logic [11:0] ex [0:18] = '{12'h237, 12'h306, 12'h202, 12'h804, 12'h808, 12'h100, 12'h0a0,
        12'h0a0, 12'h0a0, 12'h140, 12'h9ff, 12'h2be, 12'h230, 12'h130, 12'h1c0, 12'h1c1,
        12'h160, 12'h2ba, 12'h307};
    idt_prog_mem u_idt_prog_mem (.i_sys_clk(clk), .i_rst(rst), .i_run(run), .i_ready(frdy),
        .o_valid(fv), .o_word(fw), .o_cond(cond));
    idt_decoder u_idt_decoder (.i_sys_clk(clk), .i_rst(rst), .i_fetch_word(fw),
        .i_fetch_valid(fv), .o_fetch_ready(frdy), .i_cond_true(cond), .i_flag_upd(fu),
        .i_zero_sticky(zs), .o_dec(dec), .o_dec_valid(dv), .o_nop_cycle(nop), .o_flags(fl),
        .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr),
        .o_s_axi_bresp(br), .o_s_axi_bvalid(bv), .i_s_axi_bready(bry),
        .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
        .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry));
    initial forever #50 clk = ~clk;
    always @(negedge clk) begin
        if (dv === 1'b1 && nd < 32) begin
            rec[nd] = dec;
            nd++;
        end
        if (nop === 1'b1) nn++;
    end
    // ========================================
    // tasks
    task automatic final_report();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
        if (s == "wait") final_report();
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (!(bv === 1'b1 && !awv && !wv) && n < 40);
        bry <= 1'b0;
        if (bv !== 1'b1) chk("wait", 32'h1, 32'h0);
        chk("bresp", 32'(e), 32'(br));
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [1:0] e, output logic [31:0] d);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (!(rv === 1'b1 && !arv) && n < 40);
        rry <= 1'b0;
        d = rd;
        if (rv !== 1'b1) chk("wait", 32'h1, 32'h0);
        chk("rresp", 32'(e), 32'(rr));
        @(posedge clk);
    endtask : axr
    // ========================================
    // main sequence
    initial begin
        int k;
        k = 0;
        for (int i = 0; i < 64; i++) u_idt_prog_mem.mem[i] = (i < 25) ? prog[i][24:0] : 25'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axw(idt_pkg::REG_CTRL, 32'h1, idt_pkg::RESP_OKAY);
        run <= 1'b1;
        repeat (6) @(posedge clk);
        chk("held decodes", 32'h0, 32'(nd));
        axw(idt_pkg::REG_CTRL, 32'h0, idt_pkg::RESP_OKAY);
        while (nd < 19 && k < 400) begin
            @(negedge clk);
            #1;
            k++;
        end
        if (nd < 19) chk("wait", 32'h1, 32'h0);
        repeat (2) @(negedge clk);
        #1;
        for (int i = 0; i < 19; i++) begin
            chk("opcode", 32'(ex[i][7:0]), 32'(rec[i].opcode));
            chk("illegal", 32'(ex[i][11]), 32'(rec[i].illegal));
            if (ex[i][10:8] != 3'h0) chk("cycles", 32'(ex[i][10:8]), 32'(rec[i].cycles));
        end
        chk("nop cycles", 32'd11, 32'(nn));
        chk("pair addr", 32'h851234, 32'({rec[2].dbl, rec[2].program_address_literal}));
        chk("square", 32'h112, 32'({rec[14].acc_b, rec[14].mul_x, rec[14].mul_y,
            rec[14].accum_result_store_target}));
        chk("mac pair", 32'h515, 32'({rec[15].acc_b, rec[15].mul_x, rec[15].mul_y,
            rec[15].accum_result_store_target}));
        chk("store reg", 32'hd, 32'(rec[14].result_register));
        @(posedge clk);
        fu <= {9'h1ff, 9'h1bb};
        @(posedge clk);
        fu <= {9'h010, 9'h000};
        zs <= 1'b1;
        @(posedge clk);
        fu <= {9'h010, 9'h010};
        @(posedge clk);
        fu <= '0;
        zs <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("flags", 32'h1ab, 32'(fl));
        axr(idt_pkg::REG_STATUS, idt_pkg::RESP_OKAY, v);
        chk("status", 32'h000101ab, v);
        axw(idt_pkg::REG_STATUS, 32'h000101ab, idt_pkg::RESP_OKAY);
        axr(idt_pkg::REG_STATUS, idt_pkg::RESP_OKAY, v);
        chk("status cleared", 32'h000001ab, v);
        axw(8'h44, 32'h1, idt_pkg::RESP_SLVERR);
        axr(8'h40, idt_pkg::RESP_SLVERR, v);
        chk("unmapped data", 32'h0, v);
        final_report();
    end
endmodule : idt_decoder_bench
`default_nettype wire
